// file: design/gcx_pkg.sv
`default_nettype none

package gcx_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned REN_QUIET_US = 100;
  localparam int unsigned REN_QUIET_CYC = REN_QUIET_US * (CLK_HZ / 1_000_000);
  localparam int unsigned QUIET_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_AUX_CMD = 8'h00;
  localparam logic [7:0] OFS_CTRL_STAT = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;

  // Auxiliary command codes
  localparam logic [7:0] CMD_CLR_SRE = 8'h10;
  localparam logic [7:0] CMD_SET_SRE = 8'h90;
  localparam logic [7:0] CMD_RQC = 8'h11;
  localparam logic [7:0] CMD_RLC = 8'h12;
  localparam logic [7:0] CMD_CLR_DAI = 8'h13;
  localparam logic [7:0] CMD_SET_DAI = 8'h93;
  localparam logic [7:0] CMD_CHIP_RESET = 8'h40;

  // Interrupt status and mask layout
  localparam int unsigned INT_W = 3;
  localparam int unsigned INT_BIT_ACTIVE = 0;
  localparam int unsigned INT_BIT_IDLE = 1;
  localparam int unsigned INT_BIT_QUIET = 2;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  // Control and status register layout
  localparam int unsigned ST_BIT_SRE = 0;
  localparam int unsigned ST_BIT_RSC = 1;
  localparam int unsigned ST_BIT_SYSCTL = 2;
  localparam int unsigned ST_BIT_DAI = 3;
  localparam int unsigned ST_BIT_QUIET = 4;
  localparam int unsigned ST_POS_STATE = 5;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_WAIT = 3'b010,
    CTL_ACTIVE = 3'b100
  } gcx_ctl_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gcx_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gcx_wb_rsp_t;

  typedef struct packed {
    logic ren_o;
    logic ren_oe;
    logic atn_o;
    logic atn_oe;
  } gcx_pin_out_t;

endpackage : gcx_pkg

`default_nettype wire

// file: design/gcx_sync.sv
`default_nettype none

module gcx_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import gcx_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } gcx_sync_st_t;

  gcx_sync_st_t st_q;
  gcx_sync_st_t st_d;

  always_comb begin
    st_d.meta = async_i;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.sync;

endmodule : gcx_sync

`default_nettype wire

// file: design/gcx_irq.sv
`default_nettype none

module gcx_irq (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [gcx_pkg::INT_W-1:0] event_i,
  input wire logic clr_wr_i,
  input wire logic mask_wr_i,
  input wire logic [gcx_pkg::INT_W-1:0] wdata_i,
  input wire logic pin_disable_i,
  input wire logic soft_reset_i,
  output logic [gcx_pkg::INT_W-1:0] status_o,
  output logic [gcx_pkg::INT_W-1:0] mask_o,
  output logic irq_o
);
  import gcx_pkg::*;

  typedef struct packed {
    logic [INT_W-1:0] status;
    logic [INT_W-1:0] mask;
    logic irq;
  } gcx_irq_st_t;

  gcx_irq_st_t st_q;
  gcx_irq_st_t st_d;

  always_comb begin
    st_d = st_q;
    // Write-one-to-clear; an event in the same cycle wins
    if (clr_wr_i) begin
      st_d.status = st_q.status & ~wdata_i;
    end
    // Status keeps collecting while the pin is disabled
    st_d.status = st_d.status | event_i;
    if (mask_wr_i) begin
      st_d.mask = wdata_i;
    end
    if (soft_reset_i) begin
      st_d.mask = INT_MASK_RST;
    end
    st_d.irq = (|(st_d.status & st_d.mask)) & ~pin_disable_i;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign status_o = st_q.status;
  assign mask_o = st_q.mask;
  assign irq_o = st_q.irq;

endmodule : gcx_irq

`default_nettype wire

// file: design/gcx_aux_top.sv
// The address map and register access over Wishbone were chosen for this implementation.
`default_nettype none

module gcx_aux_top #(
  parameter int unsigned REN_QUIET_CYCLES = gcx_pkg::REN_QUIET_CYC
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire gcx_pkg::gcx_wb_req_t wb_req_i,
  output gcx_pkg::gcx_wb_rsp_t wb_rsp_o,
  input wire logic atn_line_i,
  input wire logic ren_line_i,
  output gcx_pkg::gcx_pin_out_t pins_o,
  output logic sys_ctl_o,
  output logic [gcx_pkg::INT_W-1:0] holdoff_mask_o,
  output logic irq_o
);
  import gcx_pkg::*;

  typedef struct packed {
    gcx_ctl_state_t ctl;
    logic sre;
    logic rsc;
    logic dai;
    logic [QUIET_W-1:0] quiet_cnt;
    logic quiet;
    logic ack;
    logic [31:0] rdata;
    gcx_pin_out_t pins;
  } gcx_top_st_t;

  typedef struct packed {
    logic set_sre;
    logic clr_sre;
    logic rqc;
    logic rlc;
    logic set_dai;
    logic clr_dai;
    logic chip_reset;
  } gcx_cmd_strobe_t;

  localparam logic [QUIET_W-1:0] QUIET_MAX = QUIET_W'(REN_QUIET_CYCLES);

  gcx_top_st_t st_q;
  gcx_top_st_t st_d;

  logic [1:0] line_sync;
  logic atn_seen;
  logic ren_seen;
  logic access;
  logic wr_commit;
  logic lane0;
  logic cmd_wr;
  logic [7:0] cmd;
  logic pulse_rqc;
  logic pulse_rlc;
  logic pulse_chip_reset;
  logic clr_wr;
  logic mask_wr;
  logic [INT_W-1:0] events;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  gcx_cmd_strobe_t strobe;

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  function automatic logic [31:0] ctrl_word(input gcx_top_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ST_BIT_SRE] = s.sre;
    w[ST_BIT_RSC] = s.rsc;
    w[ST_BIT_SYSCTL] = s.sre & s.rsc;
    w[ST_BIT_DAI] = s.dai;
    w[ST_BIT_QUIET] = s.quiet;
    w[ST_POS_STATE +: 3] = s.ctl;
    ctrl_word = w;
  endfunction : ctrl_word

  // One strobe per known code; unknown codes and non-writes give none
  function automatic gcx_cmd_strobe_t decode_cmd(input logic wr,
      input logic [7:0] code);
    gcx_cmd_strobe_t s;
    s = '0;
    if (wr) begin
      case (code)
        CMD_SET_SRE: begin
          s.set_sre = 1'b1;
        end
        CMD_CLR_SRE: begin
          s.clr_sre = 1'b1;
        end
        CMD_RQC: begin
          s.rqc = 1'b1;
        end
        CMD_RLC: begin
          s.rlc = 1'b1;
        end
        CMD_SET_DAI: begin
          s.set_dai = 1'b1;
        end
        CMD_CLR_DAI: begin
          s.clr_dai = 1'b1;
        end
        CMD_CHIP_RESET: begin
          s.chip_reset = 1'b1;
        end
        default: begin
        end
      endcase
    end
    decode_cmd = s;
  endfunction : decode_cmd

  // Unmapped offsets and the command register read as zero
  function automatic logic [31:0] read_word(input logic [7:0] adr,
      input logic [31:0] ctrl, input logic [INT_W-1:0] stat,
      input logic [INT_W-1:0] mask);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (adr)
      OFS_CTRL_STAT: begin
        w = ctrl;
      end
      OFS_INT_STAT: begin
        w[INT_W-1:0] = stat;
      end
      OFS_INT_MASK: begin
        w[INT_W-1:0] = mask;
      end
      default: begin
      end
    endcase
    read_word = w;
  endfunction : read_word

  // Release wins over request; chip reset returns to Idle as well
  function automatic gcx_ctl_state_t next_ctl(input gcx_ctl_state_t cur,
      input logic rqc, input logic rlc, input logic chip_reset,
      input logic atn);
    gcx_ctl_state_t n;
    n = cur;
    case (cur)
      CTL_IDLE: begin
        if (rqc) begin
          n = CTL_WAIT;
        end
      end
      CTL_WAIT: begin
        if (~atn) begin
          n = CTL_ACTIVE;
        end
      end
      CTL_ACTIVE: begin
      end
      default: begin
        n = CTL_IDLE;
      end
    endcase
    if (rlc | chip_reset) begin
      n = CTL_IDLE;
    end
    next_ctl = n;
  endfunction : next_ctl

  gcx_sync #(
    .W(2)
  ) u_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .async_i({ren_line_i, atn_line_i}),
    .sync_o(line_sync)
  );

  assign atn_seen = line_sync[0];
  assign ren_seen = line_sync[1];

  // Bus side: ack one cycle after the request, write takes effect with ack
  assign access = wb_req_i.cyc & wb_req_i.stb;
  assign wr_commit = access & wb_req_i.we & st_q.ack;
  assign lane0 = wb_req_i.sel[0];
  assign cmd_wr = wr_commit & lane0 & hit(wb_req_i.adr, OFS_AUX_CMD);
  assign cmd = wb_req_i.dat[7:0];
  assign clr_wr = wr_commit & lane0 & hit(wb_req_i.adr, OFS_INT_STAT);
  assign mask_wr = wr_commit & lane0 & hit(wb_req_i.adr, OFS_INT_MASK);

  // Control commands exist only as these one-cycle strobes
  assign strobe = decode_cmd(cmd_wr, cmd);
  assign pulse_rqc = strobe.rqc;
  assign pulse_rlc = strobe.rlc;
  assign pulse_chip_reset = strobe.chip_reset;

  always_comb begin
    st_d = st_q;

    // Bus answer
    st_d.ack = access & ~st_q.ack;
    st_d.rdata = 32'h0000_0000;
    if (access & ~st_q.ack & ~wb_req_i.we) begin
      st_d.rdata = read_word(wb_req_i.adr, ctrl_word(st_q), int_status,
        int_mask);
    end

    // Local message commands
    if (strobe.set_sre) begin
      st_d.sre = 1'b1;
      st_d.rsc = 1'b1;
    end
    if (strobe.clr_sre) begin
      st_d.sre = 1'b0;
      st_d.rsc = 1'b0;
    end
    if (strobe.set_dai) begin
      st_d.dai = 1'b1;
    end
    if (strobe.clr_dai) begin
      st_d.dai = 1'b0;
    end

    // Controller states
    st_d.ctl = next_ctl(st_q.ctl, pulse_rqc, pulse_rlc, pulse_chip_reset,
      atn_seen);

    if (pulse_chip_reset) begin
      st_d.sre = 1'b0;
      st_d.rsc = 1'b0;
      st_d.dai = 1'b0;
    end

    // Time REN has been seen deasserted on the bus
    if (ren_seen) begin
      st_d.quiet_cnt = '0;
    end else if (st_q.quiet_cnt != QUIET_MAX) begin
      st_d.quiet_cnt = st_q.quiet_cnt + QUIET_W'(1);
    end
    st_d.quiet = (st_d.quiet_cnt == QUIET_MAX);

    // Pin drive follows the next state so pins match the status word
    st_d.pins.ren_o = st_d.sre & st_d.rsc;
    st_d.pins.ren_oe = st_d.sre & st_d.rsc;
    st_d.pins.atn_o = (st_d.ctl == CTL_ACTIVE);
    st_d.pins.atn_oe = (st_d.ctl == CTL_ACTIVE);
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_q.ctl <= CTL_IDLE;
      st_q.sre <= 1'b0;
      st_q.rsc <= 1'b0;
      st_q.dai <= 1'b0;
      st_q.quiet_cnt <= '0;
      st_q.quiet <= 1'b0;
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h0000_0000;
      st_q.pins <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Events raised on controller transitions and when REN has been quiet
  assign events[INT_BIT_ACTIVE] =
    (st_d.ctl == CTL_ACTIVE) & (st_q.ctl != CTL_ACTIVE);
  assign events[INT_BIT_IDLE] =
    (st_d.ctl == CTL_IDLE) & (st_q.ctl == CTL_ACTIVE);
  assign events[INT_BIT_QUIET] = st_d.quiet & ~st_q.quiet;

  gcx_irq u_irq (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .event_i(events),
    .clr_wr_i(clr_wr),
    .mask_wr_i(mask_wr),
    .wdata_i(wb_req_i.dat[INT_W-1:0]),
    .pin_disable_i(st_d.dai),
    .soft_reset_i(1'b0),
    .status_o(int_status),
    .mask_o(int_mask),
    .irq_o(irq_o)
  );

  assign wb_rsp_o.ack = st_q.ack;
  assign wb_rsp_o.dat = st_q.rdata;
  assign pins_o = st_q.pins;
  assign sys_ctl_o = st_q.pins.ren_oe;
  // Mask-driven holdoffs are independent of the pin disable
  assign holdoff_mask_o = int_mask;

endmodule : gcx_aux_top

`default_nettype wire

// file: test/gcx_checker.sv
`default_nettype none
module gcx_checker #(
  parameter int unsigned REN_QUIET_CYCLES = 50
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire gcx_pkg::gcx_wb_req_t wb_req_i,
  input wire gcx_pkg::gcx_wb_rsp_t wb_rsp_o,
  input wire logic atn_line_i,
  input wire logic ren_line_i,
  input wire gcx_pkg::gcx_pin_out_t pins_o,
  input wire logic sys_ctl_o,
  input wire logic [gcx_pkg::INT_W-1:0] holdoff_mask_o,
  input wire logic irq_o
);
  import gcx_pkg::*;
  logic wr_c;
  logic dai_q;
  logic sre_q;
  assign wr_c = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we &&
    wb_rsp_o.ack && wb_req_i.sel[0] && wb_req_i.adr == OFS_AUX_CMD;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_cmd(logic [7:0] c);
    wr_c && wb_req_i.dat[7:0] == c;
  endsequence
  // Tracks the pin disable as commanded
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      dai_q <= 1'b0;
    end else if (wr_c && wb_req_i.dat[7:0] == CMD_SET_DAI) begin
      dai_q <= 1'b1;
    end else if (wr_c && (wb_req_i.dat[7:0] == CMD_CLR_DAI ||
        wb_req_i.dat[7:0] == CMD_CHIP_RESET)) begin
      dai_q <= 1'b0;
    end
  end
  // Tracks the remote enable request as commanded
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sre_q <= 1'b0;
    end else if (wr_c && wb_req_i.dat[7:0] == CMD_SET_SRE) begin
      sre_q <= 1'b1;
    end else if (wr_c && (wb_req_i.dat[7:0] == CMD_CLR_SRE ||
        wb_req_i.dat[7:0] == CMD_CHIP_RESET)) begin
      sre_q <= 1'b0;
    end
  end
  AST_ACK: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
    |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack) else $error("ack timing");
  AST_SET: assert property (s_cmd(CMD_SET_SRE) |=>
    sys_ctl_o && pins_o.ren_o && pins_o.ren_oe) else $error("set sre");
  AST_CLR: assert property (s_cmd(CMD_CLR_SRE) |=>
    !sys_ctl_o && !pins_o.ren_oe) else $error("clear sre");
  AST_CHR: assert property (s_cmd(CMD_CHIP_RESET) |=>
    !sys_ctl_o && !pins_o.ren_o) else $error("chip reset");
  AST_REN: assert property (sys_ctl_o == sre_q &&
    pins_o.ren_o == sre_q && pins_o.ren_oe == sre_q) else $error("ren drive");
  AST_RQC: assert property ($rose(pins_o.atn_oe) |->
    !$past(atn_line_i, 2) || !$past(atn_line_i, 3)) else $error("rqc");
  AST_RLC: assert property (s_cmd(CMD_RLC) |=>
    (!pins_o.atn_oe && !pins_o.atn_o) [*3]) else $error("rlc");
  AST_DAI: assert property (dai_q |-> !irq_o)
    else $error("pin disable");
  AST_MSK: assert property (s_cmd(CMD_SET_DAI) |=>
    $stable(holdoff_mask_o)) else $error("mask moved");
endmodule : gcx_checker
bind gcx_aux_top gcx_checker #(.REN_QUIET_CYCLES(REN_QUIET_CYCLES)) i_chk (
  .clock_i(clock_i), .reset_i(reset_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .atn_line_i(atn_line_i), .ren_line_i(ren_line_i),
  .pins_o(pins_o), .sys_ctl_o(sys_ctl_o),
  .holdoff_mask_o(holdoff_mask_o), .irq_o(irq_o));
`default_nettype wire

// file: test/gcx_far_end.sv
`default_nettype none
module gcx_far_end (
  input wire gcx_pkg::gcx_pin_out_t pins_i,
  input wire logic atn_hold_i,
  output logic atn_line_o,
  output logic ren_line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import gcx_pkg::*;
  // Wired bus: any party asserting wins
  assign atn_line_o = atn_hold_i | (pins_i.atn_oe & pins_i.atn_o);
  assign ren_line_o = pins_i.ren_oe & pins_i.ren_o;
endmodule : gcx_far_end
`default_nettype wire

// file: test/testbench.sv
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import gcx_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic atn_hold = 1'b0;
  logic atn_line, ren_line, sys_ctl, irq;
  logic [INT_W-1:0] hmask;
  logic [31:0] rd;
  gcx_wb_req_t req = '0;
  gcx_wb_rsp_t rsp;
  gcx_pin_out_t pins;
  int failures = 0;
  int compares = 0;
  always #2.5 clock_i = ~clock_i;
  gcx_aux_top #(.REN_QUIET_CYCLES(50)) i_gcx_aux_top (.clock_i(clock_i),
    .reset_i(reset_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .atn_line_i(atn_line), .ren_line_i(ren_line), .pins_o(pins),
    .sys_ctl_o(sys_ctl), .holdoff_mask_o(hmask), .irq_o(irq));
  gcx_far_end i_gcx_far_end (.pins_i(pins), .atn_hold_i(atn_hold),
    .atn_line_o(atn_line), .ren_line_o(ren_line));
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n = 0;
    @(posedge clock_i);
    req <= '{cyc:1'b1, stb:1'b1, we:w, adr:a, sel:4'h1, dat:d};
    do begin
      @(posedge clock_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (rsp.ack !== 1'b1) begin
      failures++;
      results();
    end
    rd = rsp.dat;
    req <= '0;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : wb
  task automatic cmd(input logic [7:0] c);
    wb(1'b1, OFS_AUX_CMD, {24'h0, c});
  endtask : cmd
  // Waits for REN quiet before any set request
  task automatic quiet;
    int n = 0;
    do begin
      wb(1'b0, OFS_CTRL_STAT, 32'h0);
      n++;
    end while (rd[ST_BIT_QUIET] !== 1'b1 && n < 100);
    `CHK("quiet", 1'b1, rd[ST_BIT_QUIET]);
  endtask : quiet
  task automatic t_sre;
    quiet();
    cmd(CMD_SET_SRE);
    `CHK("sysctl", 1'b1, sys_ctl);
    `CHK("ren", 1'b1, ren_line);
    wb(1'b0, OFS_CTRL_STAT, 32'h0);
    `CHK("sre rsc sys", 3'h7, rd[2:0]);
    cmd(CMD_CHIP_RESET);
    `CHK("ren chip", 1'b0, ren_line);
    wb(1'b0, OFS_CTRL_STAT, 32'h0);
    `CHK("quiet early", 1'b0, rd[ST_BIT_QUIET]);
    quiet();
    cmd(CMD_SET_SRE);
    cmd(CMD_CLR_SRE);
    wb(1'b0, OFS_CTRL_STAT, 32'h0);
    `CHK("sre rsc", 2'h0, rd[1:0]);
    quiet();
    cmd(CMD_SET_SRE);
    @(posedge clock_i);
    reset_i <= 1'b1;
    @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    `CHK("ren hw", 1'b0, ren_line);
    wb(1'b0, 8'h10, 32'hFFFF_FFFF);
    `CHK("unmapped", 32'h0, rd);
  endtask : t_sre
  task automatic t_ctl;
    int n;
    @(posedge clock_i);
    atn_hold <= 1'b1;
    cmd(CMD_RQC);
    repeat (8) @(negedge clock_i);
    `CHK("wait atn", 1'b0, pins.atn_oe);
    @(posedge clock_i);
    atn_hold <= 1'b0;
    for (n = 0; n < 20 && pins.atn_oe !== 1'b1; n++) @(negedge clock_i);
    `CHK("active", 1'b1, pins.atn_oe);
    wb(1'b0, OFS_CTRL_STAT, 32'h0);
    `CHK("state", 3'b100, rd[7:5]);
    cmd(CMD_RLC);
    `CHK("atn rlc", 1'b0, pins.atn_oe | atn_line);
    repeat (8) @(negedge clock_i);
    wb(1'b0, OFS_CTRL_STAT, 32'h0);
    `CHK("idle", 3'b001, rd[7:5]);
  endtask : t_ctl
  task automatic t_irq;
    wb(1'b1, OFS_INT_MASK, 32'h1);
    `CHK("irq on", 1'b1, irq);
    cmd(CMD_SET_DAI);
    `CHK("irq dai", 1'b0, irq);
    wb(1'b0, OFS_CTRL_STAT, 32'h0);
    `CHK("dai bit", 1'b1, rd[ST_BIT_DAI]);
    wb(1'b0, OFS_INT_STAT, 32'h0);
    `CHK("status", 2'h3, rd[1:0]);
    `CHK("mask", 3'h1, hmask);
    cmd(CMD_CLR_DAI);
    `CHK("irq clr", 1'b1, irq);
    cmd(CMD_SET_DAI);
    cmd(CMD_CHIP_RESET);
    `CHK("irq chip", 1'b1, irq);
    wb(1'b1, OFS_INT_STAT, 32'h7);
    `CHK("irq ack", 1'b0, irq);
  endtask : t_irq
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    t_sre();
    t_ctl();
    t_irq();
    results();
  end
endmodule : testbench
`default_nettype wire
